/* core/dcsd_pkg.sv */
// Purpose: shared constants and carrier types of the dual channel safe disable block
// Assumes: 125 MHz control clock, AXI4-Lite register access
// Notes:   terminal codes are stored as two-digit decimal values in hex form
package dcsd_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned CAT0_STOP_MS  = 200;  // longest power removal time
  localparam int unsigned OFF_LIMIT_MS  = 10;   // longest input-to-output-off time
  localparam int unsigned OFF_LIMIT_CYC = (CLK_HZ / 1000) * OFF_LIMIT_MS;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STAT   = 8'h04;
  localparam logic [7:0] OFS_IRQST  = 8'h08;
  localparam logic [7:0] OFS_IRQMSK = 8'h0C;
  localparam logic [7:0] OFS_TERM   = 8'h10;
  localparam logic [7:0] OFS_TRIP   = 8'h14;

  // control register field positions
  localparam int unsigned CTRL_SAFE_SW  = 0;
  localparam int unsigned CTRL_MON_SW   = 1;
  localparam int unsigned CTRL_MODE_LSB = 4;
  localparam int unsigned CTRL_EXT_TRIP = 8;
  localparam int unsigned CTRL_TRIP_CLR = 9;

  // reset values
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [3:0]  IRQMSK_RST = 4'h0;

  // terminal function and contact codes
  localparam logic [7:0] FN_NONE      = 8'h00;
  localparam logic [7:0] FN_SAFE_A    = 8'h77;
  localparam logic [7:0] FN_SAFE_B    = 8'h78;
  localparam logic [7:0] FN_EXT_MON   = 8'h62;
  localparam logic [1:0] CONTACT_NO   = 2'h0;
  localparam logic [1:0] CONTACT_NC   = 2'h1;

  // trip codes
  localparam logic [7:0] TRIP_NONE     = 8'h00;
  localparam logic [7:0] TRIP_SAFETY   = 8'h37;
  localparam logic [7:0] TRIP_EXTERNAL = 8'h12;

  // interrupt status bit positions
  localparam int unsigned IRQ_STOP    = 0;
  localparam int unsigned IRQ_DISCREP = 1;
  localparam int unsigned IRQ_TRIP    = 2;
  localparam int unsigned IRQ_RELEASE = 3;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // safety input trip mode
  typedef enum logic [1:0] {
    DCSD_MODE_NO_TRIP = 2'b00,
    DCSD_MODE_TRIP    = 2'b01
  } dcsd_mode_t;

  // terminal assignment carrier
  typedef struct packed {
    logic [7:0] in3_fn;
    logic [7:0] in4_fn;
    logic [1:0] in3_ct;
    logic [1:0] in4_ct;
    logic [7:0] out11_fn;
    logic [1:0] out11_ct;
  } dcsd_term_t;

  // AXI4-Lite request and answer carriers
  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } dcsd_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } dcsd_axi_rsp_t;

endpackage

/* core/dcsd_top.sv */
// Purpose: safe torque off interlock with AXI4-Lite register access
// Assumes: safety inputs high when energised; one 125 MHz clock domain
// Notes:   gate enable is cut combinationally from the raw pins
//
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module dcsd_top
  import dcsd_pkg::*;
(
  input  wire logic          i_mclk,        // control clock
  input  wire logic          i_srst,        // synchronous reset, active high
  input  wire logic          i_safe_a,      // safety_input_a pin, high = energised
  input  wire logic          i_safe_b,      // safety_input_b pin, high = energised
  input  wire logic          i_gate_req,    // drive wants the power stage switching
  input  wire dcsd_axi_req_t i_axi,         // AXI4-Lite requests
  output dcsd_axi_rsp_t      o_axi,         // AXI4-Lite answers
  output logic               o_gate_en,     // power transistor switching allowed
  output logic               o_ext_mon,     // external_monitor_output, high = conducting
  output logic               o_irq          // level interrupt
);

  // synchroniser stages, first stage only feeds the second
  logic [1:0] sync1_r, sync1_nxt;
  logic [1:0] sync2_r, sync2_nxt;
  logic [1:0] prev_r,  prev_nxt;             // last synced state for edge detect

  // control and status state
  logic [31:0] ctrl_r,   ctrl_nxt;           // switches, mode, external trip
  logic [3:0]  irqst_r,  irqst_nxt;          // sticky events
  logic [3:0]  irqmsk_r, irqmsk_nxt;         // interrupt mask
  logic [7:0]  trip_r,   trip_nxt;           // latched trip code
  logic        mon_r,    mon_nxt;            // registered monitor output

  // AXI slave state
  logic        aw_got_r, aw_got_nxt;         // write address held
  logic        w_got_r,  w_got_nxt;          // write data held
  logic [7:0]  awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r,  wdata_nxt;
  logic [3:0]  wstrb_r,  wstrb_nxt;
  logic        bvalid_r, bvalid_nxt;
  logic [1:0]  bresp_r,  bresp_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r,  rdata_nxt;
  logic [1:0]  rresp_r,  rresp_nxt;

  // derived terms
  logic        safe_sw;                      // safety switch on
  logic        mon_sw;                       // monitor switch on
  dcsd_mode_t  mode;                         // trip mode select
  dcsd_term_t  term;                         // forced terminal assignment
  logic        both_on;                      // both channels energised (synced)
  logic        wr_go;                        // write performed this cycle
  logic [3:0]  w1c;                          // status bits cleared by write
  logic [3:0]  ev;                           // events this cycle

  // byte-lane merge used by the control register write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (be[i]) res[i*8 +: 8] = nw[i*8 +: 8];
    return res;
  endfunction

  // register address decode used for read and write
  function automatic logic mapped(input logic [7:0] a);
    return (a == OFS_CTRL) || (a == OFS_STAT) || (a == OFS_IRQST) ||
           (a == OFS_IRQMSK) || (a == OFS_TERM) || (a == OFS_TRIP);
  endfunction

  assign safe_sw = ctrl_r[CTRL_SAFE_SW];
  assign mon_sw  = ctrl_r[CTRL_MON_SW];
  assign mode    = dcsd_mode_t'(ctrl_r[CTRL_MODE_LSB +: 2]);
  assign both_on = sync2_r[0] & sync2_r[1];

  always_comb
  begin
    term.in3_fn   = safe_sw ? FN_SAFE_A : FN_NONE;
    term.in4_fn   = safe_sw ? FN_SAFE_B : FN_NONE;
    term.in3_ct   = safe_sw ? CONTACT_NC : CONTACT_NO;
    term.in4_ct   = safe_sw ? CONTACT_NC : CONTACT_NO;
    term.out11_fn = mon_sw ? FN_EXT_MON : FN_NONE;
    term.out11_ct = CONTACT_NO;
  end

  // immediate cut, motor coasts, no ramp
  // a latched safety trip also holds the stage off
  always_comb
  begin
    if (!safe_sw)
      o_gate_en = i_gate_req & (trip_r == TRIP_NONE);
    else
      o_gate_en = i_gate_req & i_safe_a & i_safe_b & both_on & (trip_r == TRIP_NONE);
  end

  always_comb
  begin
    mon_nxt = mon_sw & ~sync2_r[0] & ~sync2_r[1];
  end
  assign o_ext_mon = mon_r;

  always_comb
  begin
    sync1_nxt = {i_safe_b, i_safe_a};
    sync2_nxt = sync1_r;
    prev_nxt  = sync2_r;
  end

  // events: stop, discrepancy, safety trip, release
  always_comb
  begin
    ev              = 4'h0;
    ev[IRQ_STOP]    = safe_sw & (prev_r == 2'b11) & (sync2_r != 2'b11);
    ev[IRQ_DISCREP] = safe_sw & (sync2_r[0] ^ sync2_r[1]) & (prev_r != sync2_r);
    ev[IRQ_TRIP]    = (trip_r == TRIP_NONE) & (trip_nxt == TRIP_SAFETY);
    ev[IRQ_RELEASE] = safe_sw & (prev_r != 2'b11) & (sync2_r == 2'b11);
  end

  // trip code select, safety trip wins over external
  always_comb
  begin
    trip_nxt = trip_r;
    if (safe_sw && mode == DCSD_MODE_TRIP && !both_on)
      trip_nxt = TRIP_SAFETY;
    else if (ctrl_r[CTRL_EXT_TRIP] && trip_r == TRIP_NONE)
      trip_nxt = TRIP_EXTERNAL;
    else if (ctrl_r[CTRL_TRIP_CLR] && both_on)
      trip_nxt = TRIP_NONE;
  end

  // AXI write channel and register writes
  always_comb
  begin
    aw_got_nxt = aw_got_r;
    w_got_nxt  = w_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt  = wdata_r;
    wstrb_nxt  = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt  = bresp_r;
    ctrl_nxt   = ctrl_r;
    irqmsk_nxt = irqmsk_r;
    w1c        = 4'h0;
    // clear pulse bit self-clears after one cycle
    ctrl_nxt[CTRL_TRIP_CLR] = 1'b0;
    if (i_axi.awvalid && !aw_got_r)
    begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = i_axi.awaddr;
    end
    if (i_axi.wvalid && !w_got_r)
    begin
      w_got_nxt = 1'b1;
      wdata_nxt = i_axi.wdata;
      wstrb_nxt = i_axi.wstrb;
    end
    if (bvalid_r && i_axi.bready)
      bvalid_nxt = 1'b0;
    wr_go = aw_got_r & w_got_r & ~bvalid_r;
    if (wr_go)
    begin
      aw_got_nxt = 1'b0;
      w_got_nxt  = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
      unique case (awaddr_r)
        OFS_CTRL:   ctrl_nxt   = merge(ctrl_r, wdata_r, wstrb_r);
        // lane 0 carries the whole four-bit mask
        OFS_IRQMSK: irqmsk_nxt = wstrb_r[0] ? wdata_r[3:0] : irqmsk_r;
        OFS_IRQST:  w1c        = wstrb_r[0] ? wdata_r[3:0] : 4'h0;
        default:    ;
      endcase
    end
  end

  // sticky status: a new event wins over a write-one clear
  always_comb
  begin
    irqst_nxt = (irqst_r & ~w1c) | ev;
  end

  // AXI read channel
  always_comb
  begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (rvalid_r && i_axi.rready)
      rvalid_nxt = 1'b0;
    if (i_axi.arvalid && !rvalid_r)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = mapped(i_axi.araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (i_axi.araddr)
        OFS_CTRL:   rdata_nxt = ctrl_r;
        OFS_STAT:   rdata_nxt = {26'h000_0000, mon_r, o_gate_en, both_on,
                                 sync2_r[1] ^ sync2_r[0], sync2_r};
        OFS_IRQST:  rdata_nxt = {28'h000_0000, irqst_r};
        OFS_IRQMSK: rdata_nxt = {28'h000_0000, irqmsk_r};
        OFS_TERM:   rdata_nxt = {2'h0, term};
        OFS_TRIP:   rdata_nxt = {24'h00_0000, trip_r};
        default:    rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_comb
  begin
    o_axi.awready = ~aw_got_r;
    o_axi.wready  = ~w_got_r;
    o_axi.bvalid  = bvalid_r;
    o_axi.bresp   = bresp_r;
    o_axi.arready = ~rvalid_r;
    o_axi.rvalid  = rvalid_r;
    o_axi.rdata   = rdata_r;
    o_axi.rresp   = rresp_r;
    o_irq         = |(irqst_r & irqmsk_r);
  end

  // state registers
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      sync1_r  <= 2'h0;
      sync2_r  <= 2'h0;
      prev_r   <= 2'h0;
      ctrl_r   <= CTRL_RST;
      irqst_r  <= 4'h0;
      irqmsk_r <= IRQMSK_RST;
      trip_r   <= TRIP_NONE;
      mon_r    <= 1'b0;
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= RESP_OKAY;
    end
    else
    begin
      sync1_r  <= sync1_nxt;
      sync2_r  <= sync2_nxt;
      prev_r   <= prev_nxt;
      ctrl_r   <= ctrl_nxt;
      irqst_r  <= irqst_nxt;
      irqmsk_r <= irqmsk_nxt;
      trip_r   <= trip_nxt;
      mon_r    <= mon_nxt;
      aw_got_r <= aw_got_nxt;
      w_got_r  <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r  <= wdata_nxt;
      wstrb_r  <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r  <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r  <= rdata_nxt;
      rresp_r  <= rresp_nxt;
    end
  end

  // checks
  a_gate_pin_cut: assert property (@(posedge i_mclk) disable iff (i_srst)
    (safe_sw && (!i_safe_a || !i_safe_b)) |-> !o_gate_en)
    else $error("gate enabled with a safety input open");

  a_mon_both_open: assert property (@(posedge i_mclk) disable iff (i_srst)
    (mon_sw && sync2_r == 2'b00) |=> o_ext_mon)
    else $error("monitor not conducting with both inputs open");

  a_mon_both_on: assert property (@(posedge i_mclk) disable iff (i_srst)
    (sync2_r == 2'b11) |=> !o_ext_mon)
    else $error("monitor conducting with both inputs energised");

  a_mon_one_open: assert property (@(posedge i_mclk) disable iff (i_srst)
    (sync2_r[0] != sync2_r[1]) |-> !(safe_sw && o_gate_en) ##1 !o_ext_mon)
    else $error("single open channel mishandled");

  a_term_forced: assert property (@(posedge i_mclk) disable iff (i_srst)
    safe_sw |-> term.in3_fn == FN_SAFE_A && term.in4_fn == FN_SAFE_B && term.in4_ct == CONTACT_NC)
    else $error("input terminals not forced");

  a_out11_forced: assert property (@(posedge i_mclk) disable iff (i_srst)
    mon_sw |-> term.out11_fn == FN_EXT_MON && term.out11_ct == CONTACT_NO)
    else $error("output terminal not forced");

  a_switch_off: assert property (@(posedge i_mclk) disable iff (i_srst)
    !mon_sw |=> !o_ext_mon)
    else $error("monitor active with monitor switch off");

  a_trip_prio: assert property (@(posedge i_mclk) disable iff (i_srst)
    (safe_sw && mode == DCSD_MODE_TRIP && !both_on) |=> trip_r == TRIP_SAFETY)
    else $error("safety trip not raised or lost to external trip");

  a_sync_delay: assert property (@(posedge i_mclk) disable iff (i_srst)
    (!$past(i_srst) && !$past(i_srst, 2)) |-> (sync2_r == $past({i_safe_b, i_safe_a}, 2)))
    else $error("synchroniser depth wrong");

  a_trip_gate_off: assert property (@(posedge i_mclk) disable iff (i_srst)
    (trip_r != TRIP_NONE) |-> !o_gate_en)
    else $error("gate enabled while a trip is latched");

  a_trip_held: assert property (@(posedge i_mclk) disable iff (i_srst)
    (trip_r == TRIP_SAFETY && !both_on) |=> trip_r == TRIP_SAFETY)
    else $error("safety trip lost while a channel is open");

  a_term_released: assert property (@(posedge i_mclk) disable iff (i_srst)
    !safe_sw |-> term.in3_fn == FN_NONE && term.in4_fn == FN_NONE)
    else $error("input terminals still assigned with safety switch off");

  a_out11_released: assert property (@(posedge i_mclk) disable iff (i_srst)
    !mon_sw |-> term.out11_fn == FN_NONE && term.out11_ct == CONTACT_NO)
    else $error("output terminal still assigned with monitor switch off");

  a_stop_sticky: assert property (@(posedge i_mclk) disable iff (i_srst)
    ev[IRQ_STOP] |=> irqst_r[IRQ_STOP])
    else $error("stop event not recorded");

  a_discrep_sticky: assert property (@(posedge i_mclk) disable iff (i_srst)
    ev[IRQ_DISCREP] |=> irqst_r[IRQ_DISCREP])
    else $error("discrepancy event not recorded");

endmodule
`default_nettype wire

/* verif/dcsd_safety_relay.sv */
// Purpose: behavioural external safety relay with emergency stop
// Assumes: an energised channel is a high level
// Notes:   single-channel breaks model wiring faults only
`timescale 1ns/1ps
`default_nettype none
module dcsd_safety_relay
(
  input  wire logic i_estop,    // emergency stop pressed
  input  wire logic i_break_a,  // commanded wiring fault, channel a
  input  wire logic i_break_b,  // commanded wiring fault, channel b
  input  wire logic i_ext_mon,  // monitor contact from the drive
  output logic      o_safe_a,   // channel a, high = energised
  output logic      o_safe_b,   // channel b, high = energised
  output logic      o_stop_ok   // stop confirmed through the monitor
);
  assign o_safe_a = !(i_estop || i_break_a);
  assign o_safe_b = !(i_estop || i_break_b);
  assign o_stop_ok = i_estop && i_ext_mon;
endmodule
`default_nettype wire

/* verif/tb.sv */
// Purpose: self-checking bench for the safe disable interlock
// Assumes: relay model drives the safety pins
// Notes:   registers reached through AXI4-Lite tasks
`timescale 1ns/1ps
`default_nettype none
module tb
  import dcsd_pkg::*;
;
  logic          i_mclk;       // control clock
  logic          i_srst;       // reset, active high
  logic          gate_req;     // drive wants switching
  logic          estop;        // relay opens both channels
  logic          brk_a;        // wiring fault a
  logic          brk_b;        // wiring fault b
  wire           safe_a;       // pin a
  wire           safe_b;       // pin b
  wire           stop_ok;      // relay saw the monitor
  dcsd_axi_req_t ax;           // bus requests
  dcsd_axi_rsp_t rs;           // bus answers
  wire           gate_en;      // switching allowed
  wire           ext_mon;      // monitor conducting
  wire           irq;          // interrupt
  int            n_fail;       // mismatches
  int            total_checks; // comparisons
  int            cyc = 0;      // watchdog count
  logic [31:0]   rd;           // last read data
  logic [1:0]    resp;         // last response
  logic [4:0]    rows [5];     // estop, brk_a, brk_b, gate, monitor

  dcsd_safety_relay rly (.i_estop(estop), .i_break_a(brk_a), .i_break_b(brk_b),
    .i_ext_mon(ext_mon), .o_safe_a(safe_a), .o_safe_b(safe_b), .o_stop_ok(stop_ok));
  dcsd_top uut (.i_mclk(i_mclk), .i_srst(i_srst), .i_safe_a(safe_a), .i_safe_b(safe_b),
    .i_gate_req(gate_req), .i_axi(ax), .o_axi(rs), .o_gate_en(gate_en),
    .o_ext_mon(ext_mon), .o_irq(irq));

  // clock, 8 ns period
  initial
  begin
    i_mclk = 1'h0;
    forever #4 i_mclk = ~i_mclk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // watchdog cuts a hung handshake
  always @(posedge i_mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // write: both channels offered, bready held until bvalid
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    logic b;
    @(posedge i_mclk);
    ax.awaddr  <= a;
    ax.awvalid <= 1'h1;
    ax.wdata   <= d;
    ax.wstrb   <= 4'hF;
    ax.wvalid  <= 1'h1;
    ax.bready  <= 1'h1;
    b = 1'h0;
    while (!b)
    begin
      #1;
      aw   = ax.awvalid && rs.awready;
      w    = ax.wvalid && rs.wready;
      b    = rs.bvalid;
      resp = rs.bresp;
      @(posedge i_mclk);
      if (aw) ax.awvalid <= 1'h0;
      if (w) ax.wvalid <= 1'h0;
      if (b) ax.bready <= 1'h0;
    end
  endtask

  // read: rready held until rvalid
  task automatic rdr(input logic [7:0] a);
    logic ar;
    logic r;
    @(posedge i_mclk);
    ax.araddr  <= a;
    ax.arvalid <= 1'h1;
    ax.rready  <= 1'h1;
    r = 1'h0;
    while (!r)
    begin
      #1;
      ar   = ax.arvalid && rs.arready;
      r    = rs.rvalid;
      rd   = rs.rdata;
      resp = rs.rresp;
      @(posedge i_mclk);
      if (ar) ax.arvalid <= 1'h0;
      if (r) ax.rready <= 1'h0;
    end
  endtask

  task automatic pins(input logic e, input logic a, input logic b);
    @(posedge i_mclk);
    estop <= e;
    brk_a <= a;
    brk_b <= b;
    repeat (4) @(posedge i_mclk);
    #1;
  endtask

  initial
  begin
    ax = '0;
    i_srst = 1'h1;
    gate_req = 1'h1;
    estop = 1'h0;
    brk_a = 1'h0;
    brk_b = 1'h0;
    n_fail = 0;
    total_checks = 0;
    // none, both open, a open, b open, both plus a
    rows = '{5'h02, 5'h11, 5'h08, 5'h04, 5'h19};
    repeat (12) @(posedge i_mclk);
    i_srst <= 1'h0;
    #1;
    chk("irq reset", 32'h0, irq);
    chk("monitor reset", 32'h0, ext_mon);
    rdr(OFS_CTRL);
    chk("ctrl reset", CTRL_RST, rd);
    wr(OFS_CTRL, 32'h0000_0003);
    chk("write resp", RESP_OKAY, resp);
    wr(OFS_TERM, 32'h0000_0000);
    rdr(OFS_TERM);
    chk("term on", {2'h0, FN_SAFE_A, FN_SAFE_B, CONTACT_NC, CONTACT_NC,
      FN_EXT_MON, CONTACT_NO}, rd);
    // pin table: gate cut in the same cycle, monitor after sync
    foreach (rows[i])
    begin
      @(posedge i_mclk);
      estop <= rows[i][4];
      brk_a <= rows[i][3];
      brk_b <= rows[i][2];
      #1;
      chk("gate at once", rows[i][1], gate_en);
      repeat (4) @(posedge i_mclk);
      #1;
      chk("monitor", rows[i][0], ext_mon);
      chk("gate held", rows[i][1], gate_en);
      chk("relay confirm", rows[i][4] & rows[i][0], stop_ok);
    end
    // interrupt: masked status, then unmasked, then cleared
    pins(1'h0, 1'h0, 1'h0);
    chk("irq masked", 32'h0, irq);
    rdr(OFS_IRQST);
    chk("discrepancy seen", 32'h1, rd[IRQ_DISCREP]);
    rdr(OFS_IRQMSK);
    chk("mask reset", IRQMSK_RST, rd);
    wr(OFS_IRQST, 32'h0000_000F);
    wr(OFS_IRQMSK, 32'h0000_0001);
    #1;
    chk("irq cleared", 32'h0, irq);
    pins(1'h1, 1'h0, 1'h0);
    chk("irq raised", 32'h1, irq);
    pins(1'h0, 1'h0, 1'h0);
    wr(OFS_IRQST, 32'h0000_000F);
    #1;
    chk("irq w1c", 32'h0, irq);
    // safety trip competing with external trip
    wr(OFS_CTRL, 32'h0000_0013);
    @(posedge i_mclk);
    estop <= 1'h1;
    wr(OFS_CTRL, 32'h0000_0113);
    pins(1'h0, 1'h0, 1'h0);
    rdr(OFS_TRIP);
    chk("trip code", TRIP_SAFETY, rd);
    #1;
    chk("trip blocks gate", 32'h0, gate_en);
    wr(OFS_CTRL, 32'h0000_0203);
    rdr(OFS_TRIP);
    chk("trip cleared", TRIP_NONE, rd);
    #1;
    chk("gate back", 32'h1, gate_en);
    rdr(OFS_STAT);
    chk("status all on", 32'h0000_001B, rd);
    @(posedge i_mclk);
    gate_req <= 1'h0;
    #1;
    chk("gate follows request", 32'h0, gate_en);
    @(posedge i_mclk);
    gate_req <= 1'h1;
    // external trip alone, then overtaken by a safety opening
    wr(OFS_CTRL, 32'h0000_0113);
    rdr(OFS_TRIP);
    chk("external trip", TRIP_EXTERNAL, rd);
    pins(1'h1, 1'h0, 1'h0);
    rdr(OFS_TRIP);
    chk("safety over external", TRIP_SAFETY, rd);
    pins(1'h0, 1'h0, 1'h0);
    wr(OFS_CTRL, 32'h0000_0203);
    rdr(OFS_TRIP);
    chk("trip cleared again", TRIP_NONE, rd);
    // switches off: no function, monitor stays off
    wr(OFS_CTRL, 32'h0000_0000);
    rdr(OFS_TERM);
    chk("term off", 32'h0, rd);
    pins(1'h1, 1'h0, 1'h0);
    chk("monitor off", 32'h0, ext_mon);
    pins(1'h0, 1'h0, 1'h0);
    rdr(8'h40);
    chk("unmapped resp", RESP_SLVERR, resp);
    wr(8'h40, 32'h0000_0000);
    chk("unmapped write resp", RESP_SLVERR, resp);
    print_verdict();
  end
endmodule
`default_nettype wire
